/* core/dac_pkg.sv */
// Shared constants for the DDR2 command-side device model
package dac_pkg;
	// Command pin encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_MRS = 4'h0;
	// Mode register select on bank address
	localparam logic [2:0] BA_MR = 3'h0;
	localparam logic [2:0] BA_EMR1 = 3'h1;
	// Mode register field positions
	localparam int MR_BL_LSB = 0;
	localparam int MR_CL_LSB = 4;
	localparam int EMR_RTT_A = 2;
	localparam int EMR_RTT_B = 6;
	localparam int EMR_AL_LSB = 3;
	localparam int EMR_OCD_LSB = 7;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] AL_MAX = 3'h4;
	// Driver calibration modes
	localparam logic [2:0] OCD_EXIT = 3'h0;
	localparam logic [2:0] OCD_DRV1 = 3'h1;
	localparam logic [2:0] OCD_DRV0 = 3'h2;
	localparam logic [2:0] OCD_ADJ = 3'h4;
	localparam logic [2:0] OCD_DFLT = 3'h7;
	// Adjust codes, bit time 0 in bit 0
	localparam logic [3:0] ADJ_NOP = 4'h0;
	localparam logic [3:0] ADJ_UP_INC = 4'h8;
	localparam logic [3:0] ADJ_UP_DEC = 4'h4;
	localparam logic [3:0] ADJ_DN_INC = 4'h2;
	localparam logic [3:0] ADJ_DN_DEC = 4'h1;
	localparam logic [3:0] ADJ_BOTH_INC = 4'hA;
	localparam logic [3:0] ADJ_UPD_DNI = 4'h6;
	localparam logic [3:0] ADJ_UPI_DND = 4'h9;
	localparam logic [3:0] ADJ_BOTH_DEC = 4'h5;
	// Step range, highest and lowest
	localparam logic [3:0] STEP_MAX = 4'hF;
	localparam logic [3:0] STEP_MIN = 4'h0;
	// Output switch interval
	localparam int OUTPUT_SWITCH_INTERVAL_PS = 12000;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int OSI_CYC_RAW = (OUTPUT_SWITCH_INTERVAL_PS + CLK_PERIOD_PS
		- 1) / CLK_PERIOD_PS;
	localparam logic [3:0] OSI_CYC = OSI_CYC_RAW[3:0];
	// Adjust burst length and delay line depth
	localparam logic [2:0] ADJ_BEATS = 3'h4;
	localparam int DLY_DEPTH = 16;
	typedef enum logic [2:0] {
		OCD_IDLE = 3'b001,
		OCD_WAIT = 3'b010,
		OCD_BURST = 3'b100
	} dac_ocd_type;
endpackage

/* core/dac_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dac_fifo import dac_pkg::*; #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// Pointer wrap bit needs a power-of-two depth
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("dac_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wp_reg, rp_reg;
	wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
	wire empty = wp_reg == rp_reg;
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem_reg[rp_reg[AW-1:0]];
	// Pointer update
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if (push)
				wp_reg <= wp_reg + 1'b1;
			if (pop)
				rp_reg <= rp_reg + 1'b1;
		end
	end
	// Storage, no reset needed
	always_ff @(posedge mclk) begin
		if (push)
			mem_reg[wp_reg[AW-1:0]] <= in_data;
	end
endmodule

/* core/dac_core.sv */
// DDR2 command decode, posted CAS, driver calibration and termination
`timescale 1ns/1ps
// Behaviour
// - Code bits taken in fixed bit-time order, ignoring burst type.
// - One adjustment moves drive strength of all DQ together.
// - Sixteen steps; codes past the end step do nothing.
// - Starting step may be anywhere in range.
// - Code table maps to pull-up and pull-down single steps.
// - Adjust burst arrives at write latency, additive plus column minus one.
// - Drive modes enable outputs an interval after entry, off after exit.
// - Termination pin switches termination on every data-class pin.
// - Termination works active/standby, forced off in self refresh.
// - Nominal field picks resistor pair A or B.
// - Activate: cs and ras low, cas and we high; bank, row.
// - Activate before access; column command accepted next clock.
// - Additive latency zero to four supported.
// - Posted column command held additive latency before execution.
// - Column access: ras high, cs cas low; we picks read/write.
// - Burst wraps within aligned group of its own length.
// - Read latency additive plus column; write latency one less.
// - Calibration field: exit, drive high, drive low, adjust, default.
// - Additive latency from address bits 3 to 5 of first extended write.
module dac_core import dac_pkg::*; #(
	parameter int NBANK = 8,
	parameter int ROW_W = 16,
	parameter int COL_W = 12,
	parameter int DQ_W = 8,
	parameter logic [3:0] STEP_DEFAULT = 4'h8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Command pins
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] bank,
	input wire logic [ROW_W-1:0] addr,
	// Data lines as sampled write beats
	input wire logic [DQ_W-1:0] dq_in,
	// Termination pin and self refresh state
	input wire logic odt_pin,
	input wire logic self_refresh,
	// Executed column commands via FIFO
	output logic col_valid,
	input wire logic col_ready,
	output logic [COL_W+3:0] col_data,
	output logic col_stall,
	// Burst column order
	output logic [COL_W-1:0] burst_col,
	// Bank state
	output logic [NBANK-1:0] bank_open,
	output logic [ROW_W-1:0] act_row,
	// Driver and termination state
	output logic [3:0] pullup_step,
	output logic [3:0] pulldn_step,
	output logic drive_oe,
	output logic drive_level,
	output logic termination_switch_a,
	output logic termination_switch_b,
	output logic [3:0] read_latency,
	output logic [3:0] write_latency
);
	// Bank table has eight entries for the three-bit bank; column slice must fit the address
	if (NBANK != 8 || DQ_W < 1 || COL_W < 3 || COL_W > ROW_W) begin : g_bad
		$error("dac_core parameters out of range");
	end
	// Pin inputs pass three flops; change counts when 2nd and 3rd agree
	logic [2:0] odt_sync_reg, sr_sync_reg;
	logic odt_reg, sr_reg;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			odt_sync_reg <= '0;
			sr_sync_reg <= '0;
			odt_reg <= 1'b0;
			sr_reg <= 1'b0;
		end else begin
			odt_sync_reg <= {odt_sync_reg[1:0], odt_pin};
			sr_sync_reg <= {sr_sync_reg[1:0], self_refresh};
			if (odt_sync_reg[1] == odt_sync_reg[2])
				odt_reg <= odt_sync_reg[2];
			if (sr_sync_reg[1] == sr_sync_reg[2])
				sr_reg <= sr_sync_reg[2];
		end
	end
	// Command decode
	wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire is_act = cmd == CMD_ACT;
	wire is_rd = cmd == CMD_RD;
	wire is_wr = cmd == CMD_WR;
	wire is_mr = cmd == CMD_MRS && bank == BA_MR;
	wire is_emr = cmd == CMD_MRS && bank == BA_EMR1;
	// Mode registers
	logic [2:0] bl_reg, cl_reg, al_reg, ocd_reg;
	logic rtt_a_reg, rtt_b_reg;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bl_reg <= BL_CODE_4;
			cl_reg <= 3'h3;
			al_reg <= 3'h0;
			ocd_reg <= OCD_EXIT;
			rtt_a_reg <= 1'b0;
			rtt_b_reg <= 1'b0;
		end else if (is_mr) begin
			bl_reg <= addr[MR_BL_LSB +: 3];
			cl_reg <= addr[MR_CL_LSB +: 3];
		end else if (is_emr) begin
			al_reg <= addr[EMR_AL_LSB +: 3] > AL_MAX ? AL_MAX
				: addr[EMR_AL_LSB +: 3];
			ocd_reg <= addr[EMR_OCD_LSB +: 3];
			rtt_a_reg <= addr[EMR_RTT_A];
			rtt_b_reg <= addr[EMR_RTT_B];
		end
	end
	assign read_latency = {1'b0, al_reg} + {1'b0, cl_reg};
	assign write_latency = read_latency - 4'h1;
	// Bank table and row
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bank_open <= '0;
			act_row <= '0;
		end else if (is_act) begin
			// bank opened, column accepted next clock
			bank_open[bank] <= 1'b1;
			act_row <= addr;
		end
	end
	// posted column delay line, one stage per clock
	logic [COL_W+3:0] dly_reg [DLY_DEPTH];
	logic [DLY_DEPTH-1:0] dv_reg;
	wire [COL_W+3:0] new_cmd = {is_wr, bank, addr[COL_W-1:0]};
	always_ff @(posedge mclk) begin
		if (!rstn)
			dv_reg <= '0;
		else
			dv_reg <= {dv_reg[DLY_DEPTH-2:0], is_rd | is_wr};
	end
	genvar gi;
	generate
		for (gi = 0; gi < DLY_DEPTH; gi++) begin : g_dly
			if (gi == 0) begin : g_head
				always_ff @(posedge mclk) begin
					dly_reg[gi] <= new_cmd;
				end
			end else begin : g_tail
				always_ff @(posedge mclk) begin
					dly_reg[gi] <= dly_reg[gi-1];
				end
			end
		end
	endgenerate
	// Zero latency bypasses the line
	wire exec_v = al_reg == 3'h0 ? (is_rd | is_wr) : dv_reg[al_reg - 3'h1];
	wire [COL_W+3:0] exec_d = al_reg == 3'h0 ? new_cmd
		: dly_reg[al_reg - 3'h1];
	// Executed commands buffered; stall flags lost commands
	logic fifo_ready;
	assign col_stall = exec_v && !fifo_ready;
	dac_fifo #(.WIDTH(COL_W + 4), .DEPTH(4)) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(exec_v),
		.in_ready(fifo_ready),
		.in_data(exec_d),
		.out_valid(col_valid),
		.out_ready(col_ready),
		.out_data(col_data)
	);
	// burst walks within aligned group, wrapping
	logic [2:0] beat_reg, blen_reg;
	logic [COL_W-1:0] base_reg;
	wire is_bl8 = bl_reg == BL_CODE_8;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			beat_reg <= '0;
			blen_reg <= '0;
			base_reg <= '0;
			burst_col <= '0;
		end else if (exec_v) begin
			base_reg <= exec_d[COL_W-1:0];
			blen_reg <= is_bl8 ? 3'h7 : 3'h3;
			beat_reg <= 3'h0;
			burst_col <= exec_d[COL_W-1:0];
		end else begin
			beat_reg <= beat_reg + 3'h1;
			burst_col <= {base_reg[COL_W-1:3],
				(base_reg[2:0] & ~blen_reg) |
				((base_reg[2:0] + beat_reg + 3'h1) & blen_reg)};
		end
	end
	// Adjust burst capture at write latency
	dac_ocd_type ocd_st_reg;
	logic [3:0] wait_reg, code_reg;
	logic [2:0] cnt_reg;
	logic [3:0] up_reg, dn_reg;
	wire adj_go = is_emr && addr[EMR_OCD_LSB +: 3] == OCD_ADJ;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ocd_st_reg <= OCD_IDLE;
			wait_reg <= '0;
			cnt_reg <= '0;
			code_reg <= '0;
		end else begin
			case (ocd_st_reg)
				OCD_IDLE: begin
					// first beat at write latency after the command
					// Latency one goes straight in; zero cannot be served
					if (adj_go && write_latency <= 4'h1) begin
						ocd_st_reg <= OCD_BURST;
						cnt_reg <= '0;
					end else if (adj_go) begin
						ocd_st_reg <= OCD_WAIT;
						wait_reg <= write_latency - 4'h1;
					end
				end
				OCD_WAIT: begin
					if (wait_reg <= 4'h1) begin
						ocd_st_reg <= OCD_BURST;
						cnt_reg <= '0;
					end else
						wait_reg <= wait_reg - 4'h1;
				end
				OCD_BURST: begin
					// bit time order fixed; DQ0 stands for all
					code_reg[cnt_reg[1:0]] <= dq_in[0];
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == ADJ_BEATS - 3'h1)
						ocd_st_reg <= OCD_IDLE;
				end
				default: ocd_st_reg <= OCD_IDLE;
			endcase
		end
	end
	wire code_done = ocd_st_reg == OCD_BURST && cnt_reg == ADJ_BEATS - 3'h1;
	wire [3:0] code = {dq_in[0], code_reg[2:0]};
	// decode in bit-time order, reserved gives no change
	logic up_inc, up_dec, dn_inc, dn_dec;
	always_comb begin
		up_inc = 1'b0;
		up_dec = 1'b0;
		dn_inc = 1'b0;
		dn_dec = 1'b0;
		case (code)
			ADJ_UP_INC: up_inc = 1'b1;
			ADJ_UP_DEC: up_dec = 1'b1;
			ADJ_DN_INC: dn_inc = 1'b1;
			ADJ_DN_DEC: dn_dec = 1'b1;
			ADJ_BOTH_INC: begin
				up_inc = 1'b1;
				dn_inc = 1'b1;
			end
			ADJ_UPD_DNI: begin
				up_dec = 1'b1;
				dn_inc = 1'b1;
			end
			ADJ_UPI_DND: begin
				up_inc = 1'b1;
				dn_dec = 1'b1;
			end
			ADJ_BOTH_DEC: begin
				up_dec = 1'b1;
				dn_dec = 1'b1;
			end
			default: up_inc = 1'b0;
		endcase
	end
	// independent counters; saturate; default any step
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			up_reg <= STEP_DEFAULT;
			dn_reg <= STEP_DEFAULT;
		end else if (code_done) begin
			if (up_inc && up_reg != STEP_MAX)
				up_reg <= up_reg + 4'h1;
			else if (up_dec && up_reg != STEP_MIN)
				up_reg <= up_reg - 4'h1;
			if (dn_inc && dn_reg != STEP_MAX)
				dn_reg <= dn_reg + 4'h1;
			else if (dn_dec && dn_reg != STEP_MIN)
				dn_reg <= dn_reg - 4'h1;
		end else if (is_emr && addr[EMR_OCD_LSB +: 3] == OCD_DFLT) begin
			up_reg <= STEP_DEFAULT;
			dn_reg <= STEP_DEFAULT;
		end
	end
	assign pullup_step = up_reg;
	assign pulldn_step = dn_reg;
	// drive mode outputs switch one interval after entry/exit
	logic [3:0] osi_reg;
	logic drv_tgt_reg, lvl_reg;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			osi_reg <= '0;
			drv_tgt_reg <= 1'b0;
			lvl_reg <= 1'b0;
			drive_oe <= 1'b0;
			drive_level <= 1'b0;
		end else begin
			if (is_emr) begin
				drv_tgt_reg <= addr[EMR_OCD_LSB +: 3] == OCD_DRV1 ||
					addr[EMR_OCD_LSB +: 3] == OCD_DRV0;
				lvl_reg <= addr[EMR_OCD_LSB +: 3] == OCD_DRV1;
				osi_reg <= OSI_CYC;
			end else if (osi_reg != 4'h0)
				osi_reg <= osi_reg - 4'h1;
			if (osi_reg == 4'h1) begin
				drive_oe <= drv_tgt_reg;
				drive_level <= lvl_reg;
			end
		end
	end
	// termination pin, pair select, off in self refresh
	wire odt_on = odt_reg && !sr_reg;
	assign termination_switch_a = odt_on && rtt_a_reg;
	assign termination_switch_b = odt_on && rtt_b_reg;
endmodule

/* test/dac_chk.sv */
// Concurrent checks on the DDR2 command-side core ports
`timescale 1ns/1ps
module dac_chk import dac_pkg::*; #(
	parameter int NBANK = 8,
	parameter int ROW_W = 16,
	parameter logic [3:0] STEP_DEFAULT = 4'h8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Command pins and state inputs
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] bank,
	input wire logic [ROW_W-1:0] addr,
	input wire logic self_refresh,
	// Observed outputs
	input wire logic col_valid,
	input wire logic col_stall,
	input wire logic [NBANK-1:0] bank_open,
	input wire logic [ROW_W-1:0] act_row,
	input wire logic [3:0] pullup_step,
	input wire logic [3:0] pulldn_step,
	input wire logic termination_switch_a,
	input wire logic termination_switch_b,
	input wire logic [3:0] read_latency,
	input wire logic [3:0] write_latency
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	// Single step either way, never a wrap from end to end
	function automatic logic one_step(input logic [3:0] a, input logic [3:0] b);
		return (a == b + 4'h1 && b != 4'hF) || (b == a + 4'h1 && a != 4'hF);
	endfunction
	// Command shapes
	sequence s_act;
		cmd == CMD_ACT;
	endsequence
	sequence s_col;
		cmd == CMD_RD || cmd == CMD_WR;
	endsequence
	property p_act;
		s_act |=> bank_open[$past(bank)] && act_row == $past(addr);
	endproperty
	a_act: assert property (p_act) else $error("activate not recorded");
	property p_hold;
		1'b1 |=> (($past(bank_open) & ~bank_open) == '0);
	endproperty
	a_hold: assert property (p_hold) else $error("bank closed");
	property p_lat;
		read_latency >= 4'h1 |-> write_latency == read_latency - 4'h1;
	endproperty
	a_lat: assert property (p_lat) else $error("latency pair wrong");
	// zero additive latency executes at once
	property p_al0;
		s_col ##0 read_latency == 4'h3 |=> col_valid;
	endproperty
	a_al0: assert property (p_al0) else $error("column not executed");
	property p_post;
		s_col ##0 (read_latency == 4'h5 && !col_valid) |=>
			!col_valid [*2] ##1 col_valid;
	endproperty
	a_post: assert property (p_post) else $error("posted timing wrong");
	property p_pup;
		$changed(pullup_step) |-> pullup_step == STEP_DEFAULT ||
			one_step(pullup_step, $past(pullup_step));
	endproperty
	a_pup: assert property (p_pup) else $error("pull-up jump");
	property p_pdn;
		$changed(pulldn_step) |-> pulldn_step == STEP_DEFAULT ||
			one_step(pulldn_step, $past(pulldn_step));
	endproperty
	a_pdn: assert property (p_pdn) else $error("pull-down jump");
	property p_sr;
		self_refresh [*6] |-> !termination_switch_a && !termination_switch_b;
	endproperty
	a_sr: assert property (p_sr) else $error("termination in refresh");
	// Drop only when the buffer holds data
	property p_stall;
		col_stall |-> col_valid;
	endproperty
	a_stall: assert property (p_stall) else $error("stall while empty");
endmodule
bind dac_core dac_chk #(.NBANK(NBANK), .ROW_W(ROW_W),
	.STEP_DEFAULT(STEP_DEFAULT)) u_chk (.mclk, .rstn, .cs_n, .ras_n,
	.cas_n, .we_n, .bank, .addr, .self_refresh, .col_valid, .col_stall,
	.bank_open, .act_row, .pullup_step, .pulldn_step, .termination_switch_a,
	.termination_switch_b, .read_latency, .write_latency);

/* test/dac_ctl.sv */
// Memory controller model driving commands and adjust beats
`timescale 1ns/1ps
module dac_ctl import dac_pkg::*; (
	// Clock and drop view
	input wire logic mclk,
	input wire logic col_stall,
	// Command pins
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [2:0] bank,
	output logic [15:0] addr,
	// Write data lines
	output logic [7:0] dq_in
);
	logic stall_seen;
	// Deselected bus at time zero
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		bank = 3'h0;
		addr = 16'h0000;
		dq_in = 8'h00;
		stall_seen = 1'b0;
	end
	// deselect edge after each unless back to back
	task automatic cmd(input logic [3:0] c, input logic [2:0] b,
		input logic [15:0] a, input int back);
		@(posedge mclk);
		{cs_n, ras_n, cas_n, we_n} <= c;
		bank <= b;
		addr <= a;
		#1 stall_seen = col_stall;
		if (!back) begin
			@(posedge mclk);
			{cs_n, ras_n, cas_n, we_n} <= 4'hF;
			bank <= ~b;
			addr <= ~a;
		end
	endtask
	// code on all lines, then exit
	task automatic adjust(input logic [3:0] code, input int wl);
		cmd(CMD_MRS, BA_EMR1, {6'h00, OCD_ADJ, 7'h00}, 0);
		repeat (wl - 1) @(posedge mclk);
		for (int i = 0; i < 4; i++) begin
			dq_in <= {8{code[i]}};
			@(posedge mclk);
		end
		dq_in <= ~{8{code[3]}}; // Released lines do not hold the last beat
		cmd(CMD_MRS, BA_EMR1, 16'h0000, 0);
	endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the DDR2 command-side core
`timescale 1ns/1ps
module testbench import dac_pkg::*; ();
	logic mclk, rstn, odt_pin, self_refresh, col_ready;
	logic cs_n, ras_n, cas_n, we_n, col_valid, col_stall;
	logic drive_oe, drive_level, term_a, term_b;
	logic [2:0] bank;
	logic [15:0] addr, col_data, act_row;
	logic [7:0] dq_in, bank_open;
	logic [11:0] burst_col;
	logic [3:0] pup, pdn, rl, wl, exp_up, exp_dn;
	logic [15:0] exp_q [4];
	int num_errors = 0;
	int cmp_count = 0;
	// Adjust table: code, pull-up change, pull-down change
	logic [3:0] codes [9] = '{ADJ_NOP, ADJ_UP_INC, ADJ_UP_DEC, ADJ_DN_INC,
		ADJ_DN_DEC, ADJ_BOTH_INC, ADJ_UPD_DNI, ADJ_UPI_DND, ADJ_BOTH_DEC};
	int dus [9] = '{0, 1, -1, 0, 0, 1, -1, 1, -1};
	int dds [9] = '{0, 0, 0, 1, -1, 1, 1, -1, -1};
	// Free-running 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	dac_ctl ctl (.mclk, .col_stall, .cs_n, .ras_n, .cas_n, .we_n, .bank,
		.addr, .dq_in);
	dac_core uut (.mclk, .rstn, .cs_n, .ras_n, .cas_n, .we_n, .bank, .addr,
		.dq_in, .odt_pin, .self_refresh, .col_valid, .col_ready, .col_data,
		.col_stall, .burst_col, .bank_open, .act_row, .pullup_step(pup),
		.pulldn_step(pdn), .drive_oe, .drive_level,
		.termination_switch_a(term_a), .termination_switch_b(term_b),
		.read_latency(rl), .write_latency(wl));
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	function automatic logic flag(input int s);
		case (s)
			0: return col_valid;
			1: return drive_oe;
			2: return term_a;
			default: return term_b;
		endcase
	endfunction
	// Bounded wait for a level; a miss ends the run
	task automatic wait_lvl(input int s, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (flag(s) !== v && n < 30);
		chk("flag_wait", {15'h0, v}, {15'h0, flag(s)});
		if (flag(s) !== v) finish_test();
	endtask
	// Saturating step, limited to the sixteen positions
	function automatic logic [3:0] sat(input logic [3:0] v, input int d);
		if (d > 0 && v != 4'hF) return v + 4'h1;
		if (d < 0 && v != 4'h0) return v - 4'h1;
		return v;
	endfunction
	task automatic do_adj(input int k);
		ctl.adjust(codes[k], 2);
		exp_up = sat(exp_up, dus[k]);
		exp_dn = sat(exp_dn, dds[k]);
		chk("pullup_step", {12'h0, exp_up}, {12'h0, pup});
		chk("pulldn_step", {12'h0, exp_dn}, {12'h0, pdn});
	endtask
	// Main sequence
	initial begin
		rstn = 1'b0;
		odt_pin = 1'b0;
		self_refresh = 1'b0;
		col_ready = 1'b1;
		exp_up = 4'h8;
		exp_dn = 4'h8;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(negedge mclk);
		chk("pullup_step", 16'h0008, {12'h0, pup});
		chk("read_latency", 16'h0003, {12'h0, rl});
		chk("write_latency", 16'h0002, {12'h0, wl});
		ctl.cmd(CMD_MRS, BA_MR, 16'h0032, 0);
		for (int a = 0; a < 5; a++) begin
			ctl.cmd(CMD_MRS, BA_EMR1, 16'(a << 3), 0);
			@(negedge mclk);
			chk("read_latency", 16'(a + 3), {12'h0, rl});
			chk("write_latency", 16'(a + 2), {12'h0, wl});
		end
		ctl.cmd(CMD_MRS, BA_EMR1, 16'h0010, 0);
		ctl.cmd(CMD_ACT, 3'h5, 16'h1234, 1);
		ctl.cmd(CMD_RD, 3'h5, 16'h0ABE, 0);
		@(negedge mclk);
		chk("bank_open", 16'h0020, {8'h00, bank_open});
		chk("act_row", 16'h1234, act_row);
		chk("col_valid", 16'h0000, {15'h0, col_valid});
		wait_lvl(0, 1'b1);
		chk("col_data", 16'h5ABE, col_data);
		// Start at the third column; the walk wraps inside four
		chk("burst_col", 16'h0ABE, {4'h0, burst_col});
		@(negedge mclk);
		chk("burst_col", 16'h0ABF, {4'h0, burst_col});
		@(negedge mclk);
		chk("burst_col", 16'h0ABC, {4'h0, burst_col});
		ctl.cmd(CMD_MRS, BA_EMR1, 16'h0000, 0);
		col_ready <= 1'b0;
		// Fill past depth four; the fifth is refused
		for (int i = 0; i < 5; i++) begin
			if (i < 4) exp_q[i] = {i[0], 3'h5, 9'h1FF, 3'(i)};
			ctl.cmd(i[0] ? CMD_WR : CMD_RD, 3'h5,
				{4'h0, 9'h1FF, 3'(i)}, 0);
			chk("col_stall", {15'h0, i == 4}, {15'h0, ctl.stall_seen});
		end
		@(posedge mclk);
		col_ready <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wait_lvl(0, 1'b1);
			chk("col_data", exp_q[i], col_data);
			@(posedge mclk);
		end
		@(negedge mclk);
		chk("col_valid", 16'h0000, {15'h0, col_valid});
		// Length eight runs on past the group of four
		ctl.cmd(CMD_MRS, BA_MR, 16'h0033, 0);
		ctl.cmd(CMD_RD, 3'h5, 16'h0DEC, 0);
		wait_lvl(0, 1'b1);
		chk("col_data", 16'h5DEC, col_data);
		repeat (4) @(negedge mclk);
		chk("burst_col", 16'h0DE8, {4'h0, burst_col});
		ctl.cmd(CMD_MRS, BA_MR, 16'h0032, 0);
		// Every code once, then saturate both counters
		for (int k = 0; k < 9; k++) do_adj(k);
		repeat (9) do_adj(7);
		ctl.cmd(CMD_MRS, BA_EMR1, {6'h00, OCD_DFLT, 7'h00}, 0);
		ctl.cmd(CMD_MRS, BA_EMR1, 16'h0000, 0);
		@(negedge mclk);
		chk("pullup_step", 16'h0008, {12'h0, pup});
		// Drive high then drive low, each closed by exit
		for (int d = 0; d < 2; d++) begin
			ctl.cmd(CMD_MRS, BA_EMR1,
				{6'h00, d ? OCD_DRV0 : OCD_DRV1, 7'h00}, 0);
			@(negedge mclk);
			chk("drive_oe", 16'h0000, {15'h0, drive_oe});
			wait_lvl(1, 1'b1);
			chk("drive_level", {15'h0, d == 0}, {15'h0, drive_level});
			ctl.cmd(CMD_MRS, BA_EMR1, 16'h0000, 0);
			wait_lvl(1, 1'b0);
		end
		// Termination pair select, then self refresh
		ctl.cmd(CMD_MRS, BA_EMR1, 16'h0004, 0);
		odt_pin <= 1'b1;
		wait_lvl(2, 1'b1);
		chk("term_b", 16'h0000, {15'h0, term_b});
		ctl.cmd(CMD_MRS, BA_EMR1, 16'h0040, 0);
		wait_lvl(3, 1'b1);
		chk("term_a", 16'h0000, {15'h0, term_a});
		@(posedge mclk);
		self_refresh <= 1'b1;
		wait_lvl(3, 1'b0);
		repeat (8) @(posedge mclk);
		self_refresh <= 1'b0;
		wait_lvl(3, 1'b1);
		@(posedge mclk);
		odt_pin <= 1'b0;
		wait_lvl(3, 1'b0);
		finish_test();
	end
endmodule
